// File: design/pdsq_responder.v
// Purpose: answer status queries of a power distribution unit
// Assumes: command fields and measurements are on the sys_clk domain
// Notes:   one query in flight; response held until resp_ready
`timescale 1ns/100ps
`include "pdsq_regs.vh"

// ==========================================================
module pdsq_responder #(
  parameter NUM_CH = 16,
  parameter CH_W   = 4
) (
  // clock and reset
  input  wire                 sys_clk,
  input  wire                 rst_n,
  // command
  input  wire                 cmd_valid,
  output wire                 cmd_ready,
  input  wire [7:0]           cmd_opcode,
  input  wire [1:0]           cmd_access,
  input  wire [7:0]           cmd_element,
  // response
  output reg                  resp_valid,
  input  wire                 resp_ready,
  output reg  [7:0]           resp_opcode,
  output reg  [5:0]           resp_status,
  output reg  [1:0]           resp_access,
  output reg  [47:0]          resp_data,
  // per channel measurements and state
  input  wire [NUM_CH*24-1:0] ch_current,
  input  wire [NUM_CH*16-1:0] ch_voltage,
  input  wire [NUM_CH*24-1:0] ch_overload,
  input  wire [NUM_CH-1:0]    switch_actual_state,
  input  wire [NUM_CH-1:0]    switch_requested_state,
  input  wire [NUM_CH-1:0]    ch_tripped,
  input  wire [NUM_CH-1:0]    ch_override,
  input  wire [NUM_CH*8-1:0]  ch_group,
  // main input and board
  input  wire [23:0]          in_current,
  input  wire [15:0]          in_voltage,
  input  wire [15:0]          board_temp
);

  // ==========================================================
  // states
  localparam ST_IDLE = 2'b00;
  localparam ST_EVAL = 2'b01;
  localparam ST_RESP = 2'b10;

  reg  [1:0]  state;
  reg  [7:0]  op;
  reg  [1:0]  acc;
  reg  [7:0]  elem;

  // ==========================================================
  // helpers
  function grouped;
    input [7:0] g;
    begin
      grouped = (g <= `PDSQ_GRP_MAX);
    end
  endfunction

  function in_group;
    input [7:0] g;
    input [7:0] idx;
    begin
      in_group = grouped(g) && (g == idx);
    end
  endfunction

  function signed [24:0] mag;
    input signed [23:0] a;
    begin
      mag = (a < 0) ? -$signed({a[23], a}) : $signed({a[23], a});
    end
  endfunction

  function share_bad;
    input signed [23:0] a;
    input signed [23:0] b;
    reg signed [31:0] diff;
    reg signed [31:0] big;
    begin
      diff = $signed({{8{a[23]}}, a}) - $signed({{8{b[23]}}, b});
      if (diff < 0)
        diff = -diff;
      big = (mag(a) > mag(b)) ? $signed({{7{1'b0}}, mag(a)}) : $signed({{7{1'b0}}, mag(b)});
      share_bad = (diff * `PDSQ_RATIO_DEN) > (big * `PDSQ_SHARE_NUM);
    end
  endfunction

  // ==========================================================
  // per channel flags
  wire [NUM_CH-1:0] v_present;
  wire [NUM_CH-1:0] i_high;
  wire [NUM_CH-1:0] test_fault;
  wire [NUM_CH-1:0] share_fault;

  genvar c;
  genvar d;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      wire signed [23:0] ic = ch_current[c*24 +: 24];
      wire signed [15:0] vc = ch_voltage[c*16 +: 16];
      wire signed [15:0] vi = in_voltage;
      wire signed [23:0] ol = ch_overload[c*24 +: 24];
      wire signed [31:0] vc_s = vc * `PDSQ_RATIO_DEN;
      wire signed [31:0] vi_s = vi * `PDSQ_VPRES_NUM;
      wire signed [31:0] ic_s = ic * `PDSQ_RATIO_DEN;
      wire signed [31:0] ol_s = ol * `PDSQ_IHIGH_NUM;
      wire               on_cmd = switch_requested_state[c] & ~ch_tripped[c];
      wire [NUM_CH-1:0]  mis;
      assign v_present[c] = vc_s > vi_s;
      assign i_high[c] = ic_s > ol_s;
      assign test_fault[c] = on_cmd ? ~v_present[c] : (v_present[c] | (ic > 0));
      for (d = 0; d < NUM_CH; d = d + 1) begin : g_pair
        if (d == c) begin : g_self
          assign mis[d] = 1'b0;
        end else begin : g_other
          assign mis[d] = in_group(ch_group[d*8 +: 8], ch_group[c*8 +: 8]) &&
                          share_bad(ic, ch_current[d*24 +: 24]);
        end
      end
      assign share_fault[c] = |mis;
    end
  endgenerate

  // ==========================================================
  // selection of channel or group
  reg  [CH_W-1:0]    sel;
  reg                sel_found;
  reg  signed [27:0] grp_sum;
  reg  [7:0]         grp_idx;
  reg  [7:0]         sel_grp;
  reg  [23:0]        raw_i;
  reg  [15:0]        raw_v;
  reg                is_chan;
  reg                is_grp;
  integer            i;

  always @* begin
    sel = {CH_W{1'b0}};
    sel_found = 1'b0;
    grp_sum = 28'h0;
    grp_idx = elem - `PDSQ_SEL_GRP_BASE;
    is_chan = (elem <= `PDSQ_SEL_CH_MAX);
    is_grp = (elem >= `PDSQ_SEL_GRP_BASE) && (elem <= `PDSQ_SEL_GRP_MAX);
    if (is_chan) begin
      if (elem < NUM_CH) begin
        sel = elem[CH_W-1:0];
        sel_found = 1'b1;
      end
    end else if (is_grp) begin
      for (i = NUM_CH - 1; i >= 0; i = i - 1) begin
        if (in_group(ch_group[i*8 +: 8], grp_idx)) begin
          sel = i[CH_W-1:0];
          sel_found = 1'b1;
          grp_sum = grp_sum + {{4{ch_current[i*24+23]}}, ch_current[i*24 +: 24]};
        end
      end
    end
    if (is_grp)
      raw_i = grp_sum[23:0];
    else
      raw_i = ch_current[sel*24 +: 24];
    raw_v = ch_voltage[sel*16 +: 16];
    if (op == `PDSQ_OP_INPUT) begin
      raw_i = in_current;
      raw_v = in_voltage;
    end
    sel_grp = grouped(ch_group[sel*8 +: 8]) ? ch_group[sel*8 +: 8] : `PDSQ_GRP_NONE;
    if (is_grp)
      sel_grp = grp_idx;
  end

  // ==========================================================
  // encodings
  wire [23:0] enc_i;
  wire [15:0] enc_v;
  wire [15:0] enc_t;

  pdsq_encode u_enc (
    .raw_current (raw_i),
    .raw_voltage (raw_v),
    .raw_temp    (board_temp),
    .enc_current (enc_i),
    .enc_voltage (enc_v),
    .enc_temp    (enc_t)
  );

  // ==========================================================
  // response build
  reg  [5:0]  next_status;
  reg  [47:0] next_data;
  reg         known;

  always @* begin
    next_status = `PDSQ_ST_OK;
    next_data = 48'h0;
    known = 1'b1;
    case (op)
      `PDSQ_OP_CH_MEAS: begin
        if (!is_chan && !is_grp)
          next_status = `PDSQ_ST_WRONG_ELEM;
        else if (!sel_found)
          next_status = is_chan ? `PDSQ_ST_NO_CHAN : `PDSQ_ST_NO_GROUP;
        next_data = {enc_v, enc_i, elem};
      end
      `PDSQ_OP_CH_FLAGS: begin
        if (!is_chan && !is_grp)
          next_status = `PDSQ_ST_WRONG_ELEM;
        else if (!sel_found)
          next_status = is_chan ? `PDSQ_ST_NO_CHAN : `PDSQ_ST_NO_GROUP;
        next_data = {2'b00, 1'b0, share_fault[sel], 6'h00, 8'h00, sel_grp,
                     1'b0, ch_override[sel], 1'b0, test_fault[sel],
                     1'b0, ch_tripped[sel], 1'b0, i_high[sel],
                     1'b0, v_present[sel], 1'b0, switch_requested_state[sel],
                     1'b0, switch_actual_state[sel], elem};
      end
      `PDSQ_OP_INPUT: begin
        if (elem != `PDSQ_SEL_INPUT)
          next_status = `PDSQ_ST_WRONG_ELEM;
        next_data = {enc_v, enc_i, elem};
      end
      `PDSQ_OP_TEMP: begin
        if (elem != `PDSQ_SEL_TEMP)
          next_status = `PDSQ_ST_WRONG_ELEM;
        next_data = {24'h0, enc_t, elem};
      end
      default: begin
        known = 1'b0;
        next_status = `PDSQ_ST_NO_OPCODE;
      end
    endcase
    if (known && acc != `PDSQ_ACC_READ) begin
      if (acc == `PDSQ_ACC_WRITE)
        next_status = `PDSQ_ST_NO_WRITE;
      else
        next_status = `PDSQ_ST_RW_ERR;
    end
    if (next_status != `PDSQ_ST_OK)
      next_data = {40'h0, elem};
  end

  // ==========================================================
  // sequencer
  assign cmd_ready = (state == ST_IDLE);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= 8'h00;
      acc <= 2'h0;
      elem <= 8'h00;
      resp_valid <= 1'b0;
      resp_opcode <= 8'h00;
      resp_status <= 6'h00;
      resp_access <= 2'h0;
      resp_data <= 48'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            op <= cmd_opcode;
            acc <= cmd_access;
            elem <= cmd_element;
            state <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          resp_valid <= 1'b1;
          resp_opcode <= op + 8'h01;
          resp_status <= next_status;
          resp_access <= acc;
          resp_data <= next_data;
          state <= ST_RESP;
        end
        ST_RESP: begin
          if (resp_ready) begin
            resp_valid <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          resp_valid <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: design/pdsq_regs.vh
// Purpose: constants for the pdu status query responder
// Assumes: raw measurements arrive as two's complement in the reported step units
// Notes:   definitions only
`ifndef PDSQ_REGS_VH
`define PDSQ_REGS_VH

// ==========================================================
// command and response codes
`define PDSQ_OP_CH_MEAS      8'h21
`define PDSQ_OP_CH_FLAGS     8'h25
`define PDSQ_OP_INPUT        8'h27
`define PDSQ_OP_TEMP         8'h33

// ==========================================================
// access types
`define PDSQ_ACC_READ        2'h0
`define PDSQ_ACC_WRITE       2'h1

// ==========================================================
// execution status values
`define PDSQ_ST_OK           6'h00
`define PDSQ_ST_RW_ERR       6'h01
`define PDSQ_ST_NO_WRITE     6'h03
`define PDSQ_ST_WRONG_ELEM   6'h07
`define PDSQ_ST_NO_CHAN      6'h08
`define PDSQ_ST_NO_GROUP     6'h09
`define PDSQ_ST_NO_OPCODE    6'h3e

// ==========================================================
// selector ranges
`define PDSQ_SEL_CH_MAX      8'h63
`define PDSQ_SEL_GRP_BASE    8'h64
`define PDSQ_SEL_GRP_MAX     8'h95
`define PDSQ_SEL_INPUT       8'hbe
`define PDSQ_SEL_TEMP        8'h98

// ==========================================================
// group byte values
`define PDSQ_GRP_MAX         8'h32
`define PDSQ_GRP_NONE        8'hfb

// ==========================================================
// encoding offsets (raw step units)
`define PDSQ_CUR_OFFSET      24'h7a1200
`define PDSQ_VOLT_OFFSET     16'h7d78
`define PDSQ_TEMP_OFFSET     16'h2220

// ==========================================================
// threshold ratios as numerator over ten
`define PDSQ_VPRES_NUM       6
`define PDSQ_IHIGH_NUM       3
`define PDSQ_SHARE_NUM       1
`define PDSQ_RATIO_DEN       10

`endif

// File: design/pdsq_encode.v
// Purpose: turn raw signed measurements into offset wire encodings
// Assumes: current in 0.01 A, voltage in 0.05 V, temperature in 1/32 degC steps
// Notes:   combinational; the caller registers the results
`timescale 1ns/100ps
`include "pdsq_regs.vh"

// ==========================================================
// encoder
module pdsq_encode (
  // raw inputs
  input  wire [23:0] raw_current,
  input  wire [15:0] raw_voltage,
  input  wire [15:0] raw_temp,
  // encoded outputs
  output wire [23:0] enc_current,
  output wire [15:0] enc_voltage,
  output wire [15:0] enc_temp
);

  assign enc_current = raw_current + `PDSQ_CUR_OFFSET;
  assign enc_voltage = raw_voltage + `PDSQ_VOLT_OFFSET;
  assign enc_temp    = raw_temp + `PDSQ_TEMP_OFFSET;

endmodule

// File: tb/pdsq_monitor.sv
// Purpose: port assertions for the status query responder
// Assumes: one sys_clk domain, synchronous active low rst_n
// Notes:   bound from the bench top file
`timescale 1ns/100ps
// ==========================================================
// checker
module pdsq_monitor (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // command
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [7:0]  cmd_opcode,
  input wire [1:0]  cmd_access,
  input wire [7:0]  cmd_element,
  // response
  input wire        resp_valid,
  input wire        resp_ready,
  input wire [7:0]  resp_opcode,
  input wire [5:0]  resp_status,
  input wire [47:0] resp_data
);
  reg  [7:0] last_op;
  reg  [1:0] last_acc;
  reg  [7:0] last_elem;
  wire       known;
  wire       wrong_sel;
  assign known = (last_op == 8'h21) || (last_op == 8'h25) || (last_op == 8'h27) ||
                 (last_op == 8'h33);
  assign wrong_sel = (last_op == 8'h33 && last_elem != 8'h98) ||
                     (last_op == 8'h27 && last_elem != 8'hbe);
  // ==========================================================
  // last taken command
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      last_op   <= 8'h00;
      last_acc  <= 2'h0;
      last_elem <= 8'h00;
    end else if (cmd_valid && cmd_ready) begin
      last_op   <= cmd_opcode;
      last_acc  <= cmd_access;
      last_elem <= cmd_element;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; cmd_valid && cmd_ready; endsequence
  sequence s_answer; !resp_valid ##1 resp_valid; endsequence
  sequence s_hold;
    resp_valid && $stable(resp_data) && $stable(resp_status) && $stable(resp_opcode);
  endsequence
  answer_delay_a: assert property (s_take |=> s_answer)
    else $error("response not two cycles after take");
  busy_refuse_a: assert property (s_take |=> !cmd_ready [*2])
    else $error("command accepted while busy");
  resp_hold_a: assert property (resp_valid && !resp_ready |=> s_hold)
    else $error("response changed before acceptance");
  accept_drop_a: assert property (resp_valid && resp_ready |=> !resp_valid && cmd_ready)
    else $error("response not released after acceptance");
  reply_code_a: assert property (resp_valid |-> resp_opcode == last_op + 8'h01)
    else $error("response code not command plus one");
  write_refuse_a: assert property (
    resp_valid && known && last_acc == 2'h1 |-> resp_status == 6'h03)
    else $error("write access not refused");
  elem_echo_a: assert property (resp_valid |-> resp_data[7:0] == last_elem)
    else $error("selector echo wrong");
  err_pad_a: assert property (
    resp_valid && resp_status != 6'h00 |-> resp_data[47:8] == 40'h0)
    else $error("error response payload not zero");
  sel_wrong_a: assert property (
    resp_valid && last_acc == 2'h0 && wrong_sel |-> resp_status == 6'h07)
    else $error("wrong selector not refused");
  flag_resv_a: assert property (
    resp_valid && resp_opcode == 8'h26 |-> resp_data[47:46] == 2'h0 && resp_data[43:30] == 14'h0)
    else $error("reserved flag fields not zero");
endmodule

// File: tb/pdsq_host_model.sv
// Purpose: host side acceptor of responses
// Assumes: stall gives cycles of delay before accepting
// Notes:   ready only raised while a response stands
`timescale 1ns/100ps
// ==========================================================
// host acceptor
module pdsq_host_model (
  // clock and reset
  input wire       sys_clk,
  input wire       rst_n,
  // response handshake
  input wire       resp_valid,
  input wire [3:0] stall,
  output reg       resp_ready
);
  reg [3:0] cnt;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt        <= 4'h0;
      resp_ready <= 1'b0;
    end else if (resp_valid && !resp_ready) begin
      if (cnt >= stall) begin
        resp_ready <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      resp_ready <= 1'b0;
      cnt        <= 4'h0;
    end
  end
endmodule

// File: tb/pdsq_responder_bench.sv
// Purpose: directed bench for the status query responder
// Assumes: host model accepts responses after a set stall
// Notes:   expected measurement payloads built from raw inputs plus offsets; flag payloads given as constants
`timescale 1ns/100ps
// ==========================================================
// bench top
module pdsq_responder_bench;
  localparam [23:0] CUR_OFF  = 24'h7a1200;
  localparam [15:0] VOLT_OFF = 16'h7d78;
  localparam [15:0] TEMP_OFF = 16'h2220;
  reg          sys_clk = 1'b0;
  reg          rst_n, cmd_valid;
  reg  [7:0]   cmd_opcode, cmd_element;
  reg  [1:0]   cmd_access;
  reg  [383:0] ch_current, ch_overload;
  reg  [255:0] ch_voltage;
  reg  [127:0] ch_group;
  reg  [15:0]  sw_act, sw_req, ch_tripped, ch_override, in_voltage, board_temp;
  reg  [23:0]  in_current;
  reg  [3:0]   stall;
  wire         cmd_ready, resp_valid, resp_ready;
  wire [7:0]   resp_opcode;
  wire [5:0]   resp_status;
  wire [47:0]  resp_data;
  wire [1:0]   resp_access;
  integer      fail_count, check_count, k;
  reg  [7:0]   ops [0:3];
  always #25 sys_clk = ~sys_clk;
  pdsq_responder i_pdsq_responder (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_access(cmd_access),
    .cmd_element(cmd_element), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp_opcode(resp_opcode), .resp_status(resp_status), .resp_access(resp_access),
    .resp_data(resp_data), .ch_current(ch_current), .ch_voltage(ch_voltage),
    .ch_overload(ch_overload), .switch_actual_state(sw_act), .switch_requested_state(sw_req),
    .ch_tripped(ch_tripped), .ch_override(ch_override), .ch_group(ch_group),
    .in_current(in_current), .in_voltage(in_voltage), .board_temp(board_temp));
  pdsq_host_model i_pdsq_host_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .resp_valid(resp_valid), .stall(stall), .resp_ready(resp_ready));
  // ==========================================================
  // tasks
  task chk(input string nm, input [47:0] exp, input [47:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task query(input [7:0] op, input [1:0] acc, input [7:0] el, input [5:0] st,
             input [47:0] dat);
    integer n;
    begin
      @(posedge sys_clk);
      cmd_valid   <= 1'b1;
      cmd_opcode  <= op;
      cmd_access  <= acc;
      cmd_element <= el;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      n = 0;
      while (!(resp_valid === 1'b1 && resp_ready === 1'b1) && n < 40) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      if (resp_valid !== 1'b1 || resp_ready !== 1'b1) begin
        fail_count = fail_count + 1;
        $display("mismatch handshake expected %h seen %h", 2'h3, {resp_valid, resp_ready});
      end
      chk("status", {42'h0, st}, {42'h0, resp_status});
      chk("opcode", {40'h0, op + 8'h01}, {40'h0, resp_opcode});
      chk("access", {46'h0, acc}, {46'h0, resp_access});
      chk("data", (st === 6'h00) ? dat : {40'h0, el}, resp_data);
    end
  endtask
  // ==========================================================
  // watchdog
  initial begin
    repeat (2000) @(posedge sys_clk);
    fail_count = fail_count + 1;
    report_and_stop;
  end
  // ==========================================================
  // tests
  initial begin
    fail_count = 0;
    check_count = 0;
    ops[0] = 8'h21;
    ops[1] = 8'h25;
    ops[2] = 8'h27;
    ops[3] = 8'h33;
    {rst_n, cmd_valid, cmd_opcode, cmd_access, cmd_element, stall} = 0;
    ch_current = 384'h0;
    ch_current[3*24 +: 24] = 24'h0001f4;
    ch_current[5*24 +: 24] = 24'h0001f4;
    ch_voltage = 256'h0;
    ch_voltage[3*16 +: 16] = 16'h00c8;
    ch_overload = {16{24'h0003e8}};
    {sw_act, sw_req, ch_override, ch_tripped} = {16'h0008, 16'h0008, 16'h0008, 16'h0000};
    ch_group = {16{8'hff}};
    ch_group[3*8 +: 8] = 8'h02;
    ch_group[5*8 +: 8] = 8'h02;
    {in_current, in_voltage, board_temp} = {24'h000064, 16'h012c, 16'h0320};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    query(8'h21, 2'h0, 8'h03, 6'h00, {VOLT_OFF + 16'h00c8, CUR_OFF + 24'h0001f4, 8'h03});
    query(8'h21, 2'h0, 8'h14, 6'h08, 48'h0);
    query(8'h21, 2'h0, 8'h95, 6'h09, 48'h0);
    query(8'h21, 2'h0, 8'h96, 6'h07, 48'h0);
    query(8'h21, 2'h0, 8'h66, 6'h00, {VOLT_OFF + 16'h00c8, CUR_OFF + 24'h0003e8, 8'h66});
    for (k = 0; k < 4; k = k + 1) begin
      query(ops[k], 2'h1, 8'h03, 6'h03, 48'h0);
    end
    query(8'h21, 2'h2, 8'h03, 6'h01, 48'h0);
    query(8'h27, 2'h0, 8'hbe, 6'h00, {VOLT_OFF+in_voltage, CUR_OFF+in_current, 8'hbe});
    query(8'h27, 2'h0, 8'hbf, 6'h07, 48'h0);
    query(8'h33, 2'h0, 8'h98, 6'h00, {24'h0, TEMP_OFF + board_temp, 8'h98});
    query(8'h33, 2'h0, 8'hbe, 6'h07, 48'h0);
    query(8'h41, 2'h0, 8'h03, 6'h3e, 48'h0);
    stall <= 4'h3;
    query(8'h25, 2'h0, 8'h03, 6'h00, 48'h0000_0090_5503);
    ch_current[5*24 +: 24] <= 24'h0003e8;
    ch_tripped <= 16'h0008;
    query(8'h25, 2'h0, 8'h03, 6'h00, 48'h1000_0095_5503);
    ch_group[3*8 +: 8] <= 8'h3c;
    ch_tripped <= 16'h0000;
    query(8'h25, 2'h0, 8'h03, 6'h00, 48'h0000_3ed0_5503);
    ch_voltage[3*16 +: 16] <= 16'h0064;
    query(8'h25, 2'h0, 8'h03, 6'h00, 48'h0000_3ed4_4503);
    report_and_stop;
  end
endmodule

bind pdsq_responder pdsq_monitor i_pdsq_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
  .cmd_access(cmd_access), .cmd_element(cmd_element), .resp_valid(resp_valid),
  .resp_ready(resp_ready), .resp_opcode(resp_opcode), .resp_status(resp_status),
  .resp_data(resp_data));
